/* File: core/nvw_core.sv */
`timescale 1ns/1ps
// Function
// - wiper position comes only from the scratchpad
// - decode nop, reload, store, readback commands
// - decode shift and step codes by pairs
// - shifts halve or double, steps add or subtract one
// - code b at address zero writes wiper
// - code two copies scratchpad to store
// - shifter locked during the long store
// - ready pulses low around a store
// - frame b00100 puts wiper at 0x100
// - output echoes previous frame word
// - power-on loads scratchpad from store
// - codes one and eight reload scratchpad
// - preset low forces midscale, rise reloads unless it comes while a store runs
// - empty strobe repeats last adjust command
// - write protect blocks changes except reloads and preset
// - output released while chip select high
// - output and ready are open drain
// - msb first frame, executed on select rise
// - command, address and data field split
// - odd counts reset, only 24-multiples run
// - factory store content is midscale 512
module nvw_core #(
	parameter int STORE_CYCLES = nvw_pkg::STORE_CYCLES,
	parameter int RELOAD_CYCLES = nvw_pkg::RELOAD_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic wp_n,
	input wire logic preset_reload_input_n,
	output logic sdo_out,
	output logic sdo_oe_n,
	output logic rdy_out,
	output logic rdy_oe_n,
	output logic [nvw_pkg::WIPER_W-1:0] wiper_scratchpad,
	output logic busy
);
	import nvw_pkg::*;

	// counts must fit the busy counter
	if (STORE_CYCLES < 1 || STORE_CYCLES >= (1 << CNT_W) ||
		RELOAD_CYCLES < 1 || RELOAD_CYCLES >= (1 << CNT_W)) begin : g_chk
		$error("nvw_core: busy cycle count out of range");
	end

	localparam logic [CNT_W-1:0] STORE_LAST = CNT_W'(STORE_CYCLES - 1);
	localparam logic [CNT_W-1:0] RELOAD_LAST = CNT_W'(RELOAD_CYCLES - 1);

	// link side
	nvw_frame_s frame; // last frame, static while select is high
	nvw_rb_s rb_q; // readback word for the next frame
	logic lock_q; // store lock toward the link

	// synchronised pins
	logic cs_s; // chip select, core domain
	logic tgl_s; // frame marker, core domain
	logic [1:0] pins_s; // {write protect, preset}, both active low
	logic wp_ok; // write protect released
	logic pre_hi; // preset pin high

	// edge history
	logic cs_d_q; // chip select one cycle back
	logic pre_d_q; // preset one cycle back
	logic tgl_seen_q; // frame marker already consumed

	// control state
	nvw_state_e state_q; // busy phase
	logic [CNT_W-1:0] cnt_q; // cycles left in the busy phase
	logic [WIPER_W-1:0] scratch_q; // scratchpad, drives the wiper
	logic [STORE_W-1:0] store_q [STORE_DEPTH]; // nonvolatile store
	logic [ADDR_W-1:0] pend_addr_q; // store target
	logic [STORE_W-1:0] pend_data_q; // store data
	nvw_cmd_e last_cmd_q; // last adjust command
	logic last_ok_q; // repeat allowed
	logic od_low_q; // level that open drain pins pull to

	// decode
	logic cs_rise; // frame end seen in the core
	logic data_frame; // frame carried at least one bit
	logic frame_ok; // whole frame of 24-multiple bits
	logic repeat_ok; // bare strobe with a command to repeat
	logic go; // execute this cycle
	nvw_cmd_e cmd; // command to execute
	logic [ADDR_W-1:0] addr; // address field
	logic [STORE_W-1:0] data; // data field
	logic is_adj; // shift or step command
	logic store_go; // start a store
	logic reload_go; // start a reload
	logic reload_done; // reload finishing this cycle
	logic store_done; // store finishing this cycle

	// saturating adjust of the wiper code
	function automatic logic [WIPER_W-1:0] adjust(
		input nvw_cmd_e c,
		input logic [WIPER_W-1:0] v
	);
		logic [WIPER_W-1:0] r;
		r = v;
		case (c)
			CMD_SHR_A, CMD_SHR_B: begin
				r = {1'b0, v[WIPER_W-1:1]};
			end
			CMD_DEC_A, CMD_DEC_B: begin
				r = (v == WIPER_MIN) ? WIPER_MIN : v - 10'h001;
			end
			CMD_SHL_A, CMD_SHL_B: begin
				// doubling past the top would lose the msb, so pin it
				r = v[WIPER_W-1] ? WIPER_MAX : {v[WIPER_W-2:0], 1'b0};
			end
			CMD_INC_A, CMD_INC_B: begin
				r = (v == WIPER_MAX) ? WIPER_MAX : v + 10'h001;
			end
			default: begin
				r = v;
			end
		endcase
		return r;
	endfunction

	// serial link on its own clock
	nvw_link u_link (
		.sclk(sclk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sdi(sdi),
		.lock(lock_q),
		.rb(rb_q),
		.frame(frame),
		.sdo_oe_n(sdo_oe_n)
	);

	// chip select crosses as a level
	nvw_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_cs (
		.clk(clk),
		.rst_n(rst_n),
		.d(cs_n),
		.q(cs_s)
	);

	// frame marker crosses as a toggle
	nvw_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tgl (
		.clk(clk),
		.rst_n(rst_n),
		.d(frame.tgl),
		.q(tgl_s)
	);

	// write protect and preset pins
	nvw_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_pins (
		.clk(clk),
		.rst_n(rst_n),
		.d({wp_n, preset_reload_input_n}),
		.q(pins_s)
	);

	assign wp_ok = pins_s[1];
	assign pre_hi = pins_s[0];

	// frame decode; word and count are only read once select is high
	// and the link clock has stopped, so they need no synchroniser
	always_comb begin
		cs_rise = cs_s & ~cs_d_q;
		data_frame = tgl_s != tgl_seen_q;
		// bad counts are dropped here; the link restarts its count
		frame_ok = cs_rise && data_frame && frame.cnt == 5'h00 &&
			state_q == ST_IDLE && pre_hi;
		// a strobe with no clocks repeats the adjust, never at power-up
		repeat_ok = cs_rise && !data_frame && last_ok_q &&
			state_q == ST_IDLE && pre_hi;
		go = frame_ok | repeat_ok;
		cmd = frame_ok ? nvw_cmd_e'(frame.word[CMD_LSB +: CMD_W]) :
			last_cmd_q;
		addr = frame.word[ADDR_LSB +: ADDR_W];
		data = frame.word[STORE_W-1:0];
		is_adj = cmd[2]; // codes 4-7 and 12-15
		store_go = frame_ok && wp_ok &&
			(cmd == CMD_STORE_WIPER || cmd == CMD_STORE_ANY);
		reload_go = frame_ok &&
			(cmd == CMD_RESTORE || cmd == CMD_RELOAD);
		reload_done = state_q == ST_RELOAD && cnt_q == '0;
		store_done = state_q == ST_STORE && cnt_q == '0;
	end

	// edge history
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_d_q <= 1'b1;
			pre_d_q <= 1'b1;
			tgl_seen_q <= 1'b0;
		end else begin
			cs_d_q <= cs_s;
			pre_d_q <= pre_hi;
			if (cs_rise) begin
				tgl_seen_q <= tgl_s;
			end
		end
	end

	// busy phases; reset enters a reload as power-on does
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_RELOAD;
			cnt_q <= RELOAD_LAST;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (!pre_hi) begin
						state_q <= ST_PRESET;
					end else if (store_go) begin
						state_q <= ST_STORE;
						cnt_q <= STORE_LAST;
					end else if (reload_go) begin
						state_q <= ST_RELOAD;
						cnt_q <= RELOAD_LAST;
					end
				end
				ST_RELOAD: begin
					if (!pre_hi) begin
						state_q <= ST_PRESET;
					end else if (cnt_q == '0) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				ST_STORE: begin
					// a store is never cut short; preset waits for its end
					if (cnt_q == '0) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 20'h00001;
					end
				end
				ST_PRESET: begin
					if (pre_hi && !pre_d_q) begin
						state_q <= ST_RELOAD;
						cnt_q <= RELOAD_LAST;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// scratchpad; reloads ignore write protect, edits honour it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scratch_q <= WIPER_MID;
		end else if (!pre_hi) begin
			scratch_q <= WIPER_MID;
		end else if (reload_done) begin
			scratch_q <= store_q[WIPER_ADDR][WIPER_W-1:0];
		end else if (go && wp_ok) begin
			if (cmd == CMD_WRITE && addr == WIPER_ADDR) begin
				scratch_q <= data[WIPER_W-1:0];
			end else if (is_adj) begin
				scratch_q <= adjust(cmd, scratch_q);
			end
		end
	end

	// nonvolatile store, written when the store time has run out
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < STORE_DEPTH; i++) begin
				store_q[i] <= (i == 0) ? STORE_FACTORY : STORE_BLANK;
			end
			pend_addr_q <= WIPER_ADDR;
			pend_data_q <= STORE_BLANK;
		end else if (store_go) begin
			if (cmd == CMD_STORE_ANY && addr != WIPER_ADDR) begin
				pend_addr_q <= addr; // user word
				pend_data_q <= data;
			end else begin
				pend_addr_q <= WIPER_ADDR;
				pend_data_q <= {6'h00, scratch_q};
			end
		end else if (store_done) begin
			store_q[pend_addr_q] <= pend_data_q;
		end
	end

	// readback word for the next frame, echo for everything else
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rb_q <= '0;
		end else if (go) begin
			rb_q.sel <= cmd == CMD_READ_STORE || cmd == CMD_READ_WIPER;
			if (cmd == CMD_READ_STORE) begin
				rb_q.word <= {cmd, addr, store_q[addr]};
			end else begin
				rb_q.word <= {cmd, addr, 6'h00, scratch_q};
			end
		end
	end

	// remember the last adjust command for bare strobes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_cmd_q <= CMD_NOP;
			last_ok_q <= 1'b0;
		end else if (frame_ok) begin
			last_cmd_q <= cmd;
			last_ok_q <= is_adj;
		end
	end

	// pin side outputs; open drain pins only ever pull low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdy_oe_n <= 1'b0;
			lock_q <= 1'b0;
			od_low_q <= 1'b0;
			busy <= 1'b1;
		end else begin
			rdy_oe_n <= state_q == ST_IDLE;
			// lock moves only while select has stood high, so the link
			// can take it at a frame's first edge
			if (cs_s && cs_d_q) begin
				lock_q <= state_q == ST_STORE;
			end
			od_low_q <= 1'b0;
			busy <= state_q != ST_IDLE;
		end
	end

	assign sdo_out = od_low_q;
	assign rdy_out = od_low_q;
	assign wiper_scratchpad = scratch_q;
endmodule

/* File: core/nvw_pkg.sv */
package nvw_pkg;
	// serial word layout
	localparam int WORD_W = 24; // bits per frame
	localparam int CMD_LSB = 20; // command field occupies 23..20
	localparam int ADDR_LSB = 16; // address field occupies 19..16
	localparam int CMD_W = 4; // command width
	localparam int ADDR_W = 4; // address width
	localparam int WIPER_W = 10; // wiper data width
	localparam int STORE_W = 16; // nonvolatile word width
	localparam int STORE_DEPTH = 16; // one word per address
	localparam int CNT_W = 20; // busy counter width
	localparam logic [4:0] FRAME_LAST = 5'h17; // bit index 23 wraps to 0
	localparam logic [ADDR_W-1:0] WIPER_ADDR = 4'h0; // wiper address

	// wiper codes and factory content
	localparam logic [WIPER_W-1:0] WIPER_MID = 10'h200; // midscale, 512
	localparam logic [WIPER_W-1:0] WIPER_MAX = 10'h3ff; // top end code
	localparam logic [WIPER_W-1:0] WIPER_MIN = 10'h000; // b terminal end
	localparam logic [STORE_W-1:0] STORE_FACTORY = 16'h0200; // wiper word
	localparam logic [STORE_W-1:0] STORE_BLANK = 16'h0000; // user words

	// timing
	localparam int CLK_HZ = 10000000; // core clock rate
	localparam int STORE_TIME_MS = 25; // nonvolatile store time
	localparam int STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);
	localparam int RELOAD_CYCLES = 4; // reload busy time, plain default

	// command codes
	typedef enum logic [CMD_W-1:0] {
		CMD_NOP = 4'h0, CMD_RESTORE = 4'h1, CMD_STORE_WIPER = 4'h2,
		CMD_STORE_ANY = 4'h3, CMD_SHR_A = 4'h4, CMD_SHR_B = 4'h5,
		CMD_DEC_A = 4'h6, CMD_DEC_B = 4'h7, CMD_RELOAD = 4'h8,
		CMD_READ_STORE = 4'h9, CMD_READ_WIPER = 4'ha, CMD_WRITE = 4'hb,
		CMD_SHL_A = 4'hc, CMD_SHL_B = 4'hd, CMD_INC_A = 4'he,
		CMD_INC_B = 4'hf
	} nvw_cmd_e;

	// core states, gray along idle-reload-store-preset
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RELOAD = 2'b01,
		ST_STORE = 2'b11,
		ST_PRESET = 2'b10
	} nvw_state_e;

	// link to core: last frame as seen on the link
	typedef struct packed {
		logic [WORD_W-1:0] word; // last 24 bits shifted in
		logic [4:0] cnt; // bit count modulo 24
		logic tgl; // flips at the first bit of each frame not frozen by the store lock
	} nvw_frame_s;

	// core to link: word to send in the next frame
	typedef struct packed {
		logic sel; // send word instead of the echo
		logic [WORD_W-1:0] word; // readback word
	} nvw_rb_s;
endpackage

/* File: core/nvw_sync.sv */
`timescale 1ns/1ps
module nvw_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q; // first stage, read only by q

	// two-stage synchroniser; reset is asynchronous because the link
	// clock may stand still while the core is held in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

/* File: core/nvw_link.sv */
`timescale 1ns/1ps
module nvw_link
	import nvw_pkg::*;
(
	input wire logic sclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic lock,
	input wire nvw_pkg::nvw_rb_s rb,
	output nvw_pkg::nvw_frame_s frame,
	output logic sdo_oe_n
);
	logic lock_f_q; // store lock as taken at the frame's first edge
	logic frozen; // shifter held on this edge
	logic new_frame_q; // no bit taken yet in this frame
	logic [WORD_W:0] shift_q; // one extra stage ahead of the output
	logic [4:0] cnt_q; // bits modulo 24
	logic tgl_q; // frame marker for the core
	logic [WORD_W-1:0] src; // what the next frame sends out

	// a synchroniser on sclk would go stale while the link clock stands
	// still between frames; the core moves lock only while select has
	// stood high, so it is steady when a frame's first edge reads it
	assign frozen = new_frame_q ? lock : lock_f_q;

	// readback word replaces the echo for the frame after a read
	assign src = rb.sel ? rb.word : shift_q[WORD_W-1:0];

	// chip select high arms the next frame; sclk is idle then
	always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			new_frame_q <= 1'b1;
		end else if (cs_n) begin
			new_frame_q <= 1'b1;
		end else begin
			new_frame_q <= 1'b0;
		end
	end

	// msb-first shifter and bit counter, frozen while a store runs
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
			cnt_q <= 5'h00;
			tgl_q <= 1'b0;
			lock_f_q <= 1'b0;
		end else begin
			// the lock seen at the first edge holds for the whole frame
			if (new_frame_q) begin
				lock_f_q <= lock;
			end
			if (!frozen) begin
				if (new_frame_q) begin
					shift_q <= {src, sdi};
					cnt_q <= 5'h01;
					tgl_q <= ~tgl_q;
				end else begin
					shift_q <= {shift_q[WORD_W-1:0], sdi};
					cnt_q <= (cnt_q == FRAME_LAST) ? 5'h00 :
						cnt_q + 5'h01;
				end
			end
		end
	end

	// open drain output: pull low for a zero, release otherwise
	always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
		if (!rst_n) begin
			sdo_oe_n <= 1'b1;
		end else if (cs_n) begin
			sdo_oe_n <= 1'b1;
		end else begin
			sdo_oe_n <= shift_q[WORD_W];
		end
	end

	// held static while chip select is high, when the core samples it
	assign frame = '{word: shift_q[WORD_W-1:0], cnt: cnt_q, tgl: tgl_q};
endmodule

/* File: verification/nvw_core_asserts.sv */
`timescale 1ns/1ps
module nvw_core_asserts
	import nvw_pkg::*;
#(
	parameter int STORE_CYCLES = 20,
	parameter int RELOAD_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic preset_reload_input_n,
	input wire logic sdo_out,
	input wire logic sdo_oe_n,
	input wire logic rdy_out,
	input wire logic rdy_oe_n,
	input wire logic [nvw_pkg::WIPER_W-1:0] wiper_scratchpad,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic [31:0] lo_q; // length of the present ready-low phase

	// counts ready-low cycles; preset holds busy at will, so it clears
	always_ff @(posedge clk) begin
		if (!rst_n || rdy_oe_n || !preset_reload_input_n) begin
			lo_q <= '0;
		end else begin
			lo_q <= lo_q + 32'h1;
		end
	end

	a_sdo_released: assert property (cs_n && $past(cs_n) |-> sdo_oe_n)
		else $error("serial output pulled while deselected");
	a_open_drain: assert property (sdo_out == 1'b0 && rdy_out == 1'b0)
		else $error("open drain output drives high");
	a_rdy_busy: assert property (rdy_oe_n == !busy)
		else $error("ready does not follow busy");
	a_busy_bound: assert property (lo_q <= STORE_CYCLES + 4)
		else $error("ready held low too long");
	a_preset_mid: assert property (
		$fell(preset_reload_input_n) && !busy
		|-> ##[1:6] wiper_scratchpad == WIPER_MID)
		else $error("preset did not force midscale");
	a_wp_blocks: assert property (
		$changed(wiper_scratchpad) && !wp_n && !$past(wp_n, 4)
		&& preset_reload_input_n && $past(preset_reload_input_n, 6)
		|-> $past(busy))
		else $error("wiper changed while protected");
	a_quiet_frame: assert property (
		!cs_n && !$past(cs_n, 3) && !$past(busy)
		|-> $stable(wiper_scratchpad))
		else $error("wiper changed before select rose");
	a_busy_cause: assert property (
		$rose(busy) |-> cs_n || !preset_reload_input_n)
		else $error("busy rose with no cause");

	c_store: cover property ($fell(rdy_oe_n));
	c_preset: cover property (!preset_reload_input_n && busy);
	c_protect: cover property ($changed(wiper_scratchpad) && !wp_n);
endmodule

/* File: verification/nvw_host.sv */
`timescale 1ns/1ps
module nvw_host (
	input wire logic clk,
	input wire logic sdo,
	output logic sclk,
	output logic cs_n,
	output logic sdi
);
	// link idles deselected, serial clock parked low
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	// n bits msb first, 48 ns clock; n of zero gives a bare strobe
	task automatic xfer(input logic [23:0] w, input int n,
		output logic [23:0] rx);
		rx = '0;
		@(negedge clk);
		cs_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			sdi = w[23-k];
			#22 sclk = 1'b1;
			#24 sclk = 1'b0;
			#2 rx = {rx[22:0], sdo};
		end
		// released data line must not look like a held bit
		sdi = ~sdi;
		repeat (3) @(negedge clk);
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
	$display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_top;
	import nvw_pkg::*;
	localparam int SC = 60; // short store, still longer than one frame
	logic clk, rst_n, wp_n, prn;
	logic sclk, cs_n, sdi, sdo_out, sdo_oe_n, rdy_out, rdy_oe_n, busy;
	logic sdo; // wire level with its pull-up
	logic [WIPER_W-1:0] wip;
	logic [23:0] rx;
	int n_fail, checks;

	assign sdo = sdo_oe_n ? 1'b1 : sdo_out;

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	nvw_host host (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi));
	nvw_core #(.STORE_CYCLES(SC)) uut (.clk(clk), .rst_n(rst_n),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .wp_n(wp_n),
		.preset_reload_input_n(prn), .sdo_out(sdo_out),
		.sdo_oe_n(sdo_oe_n), .rdy_out(rdy_out), .rdy_oe_n(rdy_oe_n),
		.wiper_scratchpad(wip), .busy(busy));

	task automatic stop_test;
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// bounded wait for ready; a hang ends the run
	task automatic idle;
		for (int i = 0; i < 100 && rdy_oe_n !== 1'b1; i++) @(negedge clk);
		if (rdy_oe_n !== 1'b1) begin
			n_fail++;
			stop_test;
		end
	endtask

	task automatic send(input logic [23:0] w);
		host.xfer(w, 24, rx);
		idle;
	endtask

	task automatic t_write;
		send(24'hb00100);
		`CHK(wip, 10'h100);
		send(24'hb10155);
		`CHK(wip, 10'h100);
		`CHK(rx, 24'hb00100);
	endtask

	task automatic t_adjust;
		logic [9:0] e;
		for (int c = 4; c < 16; c++) begin
			if (c < 8 || c > 11) begin
				send(24'hb00100);
				send({c[3:0], 20'h0});
				e = c < 6 ? 10'h080 : c < 8 ? 10'h0ff : c < 14 ? 10'h200 : 10'h101;
				`CHK(wip, e);
			end
		end
		host.xfer(24'h0, 0, rx);
		idle;
		`CHK(wip, 10'h102);
		send(24'hb003ff);
		send(24'he00000);
		`CHK(wip, 10'h3ff);
		send(24'hb00000);
		send(24'h600000);
		`CHK(wip, 10'h000);
	endtask

	task automatic t_store;
		send(24'hb00155);
		host.xfer(24'h200000, 24, rx);
		`CHK(rdy_oe_n, 1'b0);
		host.xfer(24'hb00033, 24, rx);
		idle;
		`CHK(wip, 10'h155);
		send(24'h900000);
		send(24'h000000);
		`CHK(rx, 24'h900155);
		send(24'ha00000);
		send(24'h000000);
		`CHK(rx, 24'ha00155);
		send(24'h321234);
		send(24'h920000);
		send(24'h000000);
		`CHK(rx, 24'h921234);
		send(24'hb000aa);
		send(24'h100000);
		`CHK(wip, 10'h155);
		send(24'hb000aa);
		send(24'h800000);
		`CHK(wip, 10'h155);
	endtask

	task automatic t_preset;
		send(24'hb000aa);
		prn = 1'b0;
		repeat (6) @(negedge clk);
		`CHK(wip, WIPER_MID);
		prn = 1'b1;
		repeat (4) @(negedge clk);
		idle;
		`CHK(wip, 10'h155);
	endtask

	task automatic t_protect;
		send(24'hb000aa);
		wp_n = 1'b0;
		repeat (4) @(negedge clk);
		send(24'hb00111);
		send(24'he00000);
		`CHK(wip, 10'h0aa);
		send(24'h800000);
		`CHK(wip, 10'h155);
		send(24'h000000);
		wp_n = 1'b1;
	endtask

	// an odd count is dropped and clears the counter for the next frame
	task automatic t_count;
		host.xfer(24'hb00077, 13, rx);
		idle;
		`CHK(wip, 10'h155);
		send(24'hb00077);
		`CHK(wip, 10'h077);
	endtask

	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		prn = 1'b1;
		n_fail = 0;
		checks = 0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		idle;
		`CHK(wip, 10'h200);
		t_write;
		t_adjust;
		t_store;
		t_preset;
		t_protect;
		t_count;
		stop_test;
	end
endmodule

bind nvw_core nvw_core_asserts #(.STORE_CYCLES(STORE_CYCLES),
	.RELOAD_CYCLES(RELOAD_CYCLES)) chk (.clk(clk), .rst_n(rst_n),
	.cs_n(cs_n), .wp_n(wp_n),
	.preset_reload_input_n(preset_reload_input_n),
	.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .rdy_out(rdy_out),
	.rdy_oe_n(rdy_oe_n), .wiper_scratchpad(wiper_scratchpad),
	.busy(busy));
